// [rtl/rmc_pkg.sv]
/*
 * rmc_pkg: constants and types of the external memory channel control.
 * assumes nothing of its surroundings; imported by name only.
 */
package rmc_pkg;
    localparam int NUM_CH = 8;
    localparam int AXI_AW = 8;
    // register word indexes
    localparam logic [5:0] CH0_IDX  = 6'h00;
    localparam logic [5:0] STAT_IDX = 6'h08;
    // channel register field positions
    localparam int BASE_LSB  = 20;
    localparam int SIZE_LSB  = 16;
    localparam int PLEN_LSB  = 14;
    localparam int PWAIT_LSB = 12;
    localparam int IWAIT_LSB = 8;
    localparam int BUS16_BIT = 7;
    localparam int RDY_BIT   = 6;
    localparam int HS_BIT    = 4;
    localparam int EN_BIT    = 3;
    localparam logic [31:0] CH_RESET  = 32'h0000_0000;
    localparam logic [31:0] CH_WMASK  = 32'hffff_ffd8;
    localparam logic [5:0]  WAIT_EXT  = 6'h3f;
    localparam logic [5:0]  WAIT_EVEN = 6'h3e;
    localparam logic [3:0]  SIZE16_MAX = 4'h9;
    localparam logic [1:0]  SZ_WORD   = 2'h2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;
    localparam logic [1:0]  STRAP_SETTLE = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BEAT = 3'b010,
        ST_FIN  = 3'b100
    } rmc_state_t;
endpackage

// [rtl/rmc_chan_decode.sv]
/*
 * rmc_chan_decode: per-channel window match and pin mode detection.
 * assumes channel registers and the access address are core_clk logic.
 */
`timescale 1ns/1ps
`default_nettype none
module rmc_chan_decode (
    input  wire logic [rmc_pkg::NUM_CH-1:0][31:0] regs,
    input  wire logic [31:0]                     addr,
    output logic      [rmc_pkg::NUM_CH-1:0]       hit,
    output logic                                 static_mode
);
    logic [rmc_pkg::NUM_CH-1:0] stat_vec;
    genvar g;
    generate
        for (g = 0; g < rmc_pkg::NUM_CH; g++) begin : g_ch
            logic [3:0]  sz;
            logic [11:0] mask;
            logic [11:0] base;
            always_comb begin
                sz = regs[g][rmc_pkg::SIZE_LSB +: 4];
                // 16-bit channels cap at 512 MB
                if (regs[g][rmc_pkg::BUS16_BIT] &&
                    sz > rmc_pkg::SIZE16_MAX) begin
                    sz = rmc_pkg::SIZE16_MAX;
                end
                // low base bits under the size are ignored
                mask = 12'hfff << sz;
                base = regs[g][rmc_pkg::BASE_LSB +: 12];
            end
            // enabled channel whose masked base matches
            assign hit[g] = regs[g][rmc_pkg::EN_BIT] &&
                ((addr[31:20] & mask) == (base & mask));
            assign stat_vec[g] = regs[g][rmc_pkg::RDY_BIT] &&
                regs[g][rmc_pkg::IWAIT_LSB];
        end
    endgenerate
    // any ready channel with low wait bit set forces static mode
    assign static_mode = |stat_vec;
endmodule // rmc_chan_decode
`default_nettype wire

// [rtl/rmc_external_memory_ctl.sv]
/*
 * rmc_external_memory_ctl: external memory channel control with an
 * AXI4-Lite register slave, boot strap capture and the access engine.
 * assumes one clock core_clk; straps and the ack/ready pin are async.
 */
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rmc_external_memory_ctl (
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [rmc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic      [1:0]                s_axi_bresp,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [rmc_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic      [31:0]               s_axi_rdata,
    output logic      [1:0]                s_axi_rresp,
    input  wire logic                      mem_req,
    input  wire logic [31:0]               mem_addr,
    input  wire logic                      mem_write,
    input  wire logic [1:0]                mem_size,
    input  wire logic                      mem_burst,
    input  wire logic [3:0]                mem_beats,
    output logic                           mem_done,
    output logic                           mem_err,
    output logic      [rmc_pkg::NUM_CH-1:0] chan_sel_n,
    output logic                           cycle_half_speed,
    output logic                           cycle_write,
    input  wire logic                      ack_ready_in,
    output logic                           ack_ready_out,
    output logic                           ack_ready_oe,
    input  wire logic [1:0]                boot_enable_straps,
    input  wire logic                      global_half_speed_strap,
    input  wire logic                      boot_width16_strap_n,
    output logic                           system_clock_half,
    output logic                           static_pin_mode
);
    typedef struct packed {
        logic                              aw_got;
        logic [5:0]                        aw_idx;
        logic                              w_got;
        logic [31:0]                       wdata;
        logic [3:0]                        wstrb;
        logic                              bvalid;
        logic [1:0]                        bresp;
        logic                              rvalid;
        logic [31:0]                       rdata;
        logic [1:0]                        rresp;
        logic [rmc_pkg::NUM_CH-1:0][31:0]  regs;
        logic [3:0]                        strap_s1;
        logic [3:0]                        strap_s2;
        logic [1:0]                        strap_cnt;
        logic                              strap_done;
        logic                              sys_half;
        logic                              pin_s1;
        logic                              pin_s2;
        rmc_pkg::rmc_state_t               state;
        logic [2:0]                        ch;
        logic [3:0]                        total;
        logic [3:0]                        beat;
        logic [3:0]                        pos;
        logic [5:0]                        cnt;
        logic                              tick;
        logic                              ack;
        logic                              err;
        logic                              wr;
        logic [rmc_pkg::NUM_CH-1:0]        sel_n;
    } rmc_st_t;

    rmc_st_t st_r;
    rmc_st_t st_nxt;
    logic [rmc_pkg::NUM_CH-1:0] hit;
    logic        stat_mode;
    logic        hit_any;
    logic [2:0]  hit_idx;
    logic [31:0] hreg;
    logic [31:0] creg;
    logic        c_rdy;
    logic        c_page;
    logic        c_ext;
    logic        c_pin;
    logic        pin_ok;
    logic [5:0]  hwait;
    logic [3:0]  plen;

    rmc_chan_decode u_dec (
        .regs        (st_r.regs),
        .addr        (mem_addr),
        .hit         (hit),
        .static_mode (stat_mode)
    );

    // wait count loaded at the start of a bus cycle
    function automatic logic [5:0] wait_load(input logic [31:0] r,
                                             input logic fst);
        logic [5:0] comb;
        comb = {r[rmc_pkg::PWAIT_LSB +: 2], r[rmc_pkg::IWAIT_LSB +: 4]};
        if (r[rmc_pkg::RDY_BIT]) begin
            wait_load = comb & rmc_pkg::WAIT_EVEN;
        end else if (r[rmc_pkg::PLEN_LSB +: 2] != 2'h0) begin
            // first beat of a page uses initial wait
            wait_load = fst ? {2'h0, r[rmc_pkg::IWAIT_LSB +: 4]}
                            : {4'h0, r[rmc_pkg::PWAIT_LSB +: 2]};
        end else if (comb == rmc_pkg::WAIT_EXT) begin
            wait_load = 6'h00;
        end else begin
            wait_load = comb;
        end
    endfunction

    // number of bus cycles for one processor request
    function automatic logic [3:0] cycles(input logic [31:0] r,
                                          input logic brst,
                                          input logic [1:0] sz,
                                          input logic [3:0] bts);
        if (r[rmc_pkg::BUS16_BIT]) begin
            // 16-bit: word or any burst is two cycles
            cycles = (brst || sz == rmc_pkg::SZ_WORD) ? 4'h2 : 4'h1;
        end else if (brst && bts != 4'h0) begin
            cycles = bts;
        end else begin
            cycles = 4'h1;
        end
    endfunction

    always_comb begin
        hit_idx = 3'h0;
        for (int i = rmc_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i); // lowest index wins
            end
        end
        hit_any = |hit;
        hreg    = st_r.regs[hit_idx];
        creg    = st_r.regs[st_r.ch];
        c_rdy   = creg[rmc_pkg::RDY_BIT];
        c_page  = !c_rdy && creg[rmc_pkg::PLEN_LSB +: 2] != 2'h0;
        c_ext   = !c_rdy && !c_page && {creg[rmc_pkg::PWAIT_LSB +: 2],
                  creg[rmc_pkg::IWAIT_LSB +: 4]} == rmc_pkg::WAIT_EXT;
        c_pin   = c_rdy || c_ext;
        // ready is active high, ack active low
        pin_ok  = c_rdy ? st_r.pin_s2 : !st_r.pin_s2;
        plen    = 4'h1 << creg[rmc_pkg::PLEN_LSB +: 2];
        hwait   = {hreg[rmc_pkg::PWAIT_LSB +: 2],
                   hreg[rmc_pkg::IWAIT_LSB +: 4]};
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.strap_s1 = {boot_enable_straps, global_half_speed_strap,
                           boot_width16_strap_n};
        st_nxt.strap_s2 = st_r.strap_s1;
        st_nxt.pin_s1 = ack_ready_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        // straps caught once they have settled through the synchroniser
        if (!st_r.strap_done) begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
            if (st_r.strap_cnt == rmc_pkg::STRAP_SETTLE) begin
                st_nxt.strap_done = 1'b1;
                st_nxt.regs[0][rmc_pkg::EN_BIT] = st_r.strap_s2[3];
                st_nxt.regs[0][rmc_pkg::HS_BIT] = !st_r.strap_s2[2];
                st_nxt.regs[0][rmc_pkg::BUS16_BIT] = !st_r.strap_s2[0];
                if (st_r.strap_s2[3]) begin
                    // rom boot: half clock if channel 0 is half speed or the global strap is low
                    st_nxt.sys_half = !(st_r.strap_s2[2] && st_r.strap_s2[1]);
                end else begin
                    st_nxt.sys_half = !st_r.strap_s2[1];
                end
            end
        end
        // write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_idx = s_axi_awaddr[rmc_pkg::AXI_AW-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = rmc_pkg::RESP_OKAY;
            if (st_r.aw_idx < 6'(rmc_pkg::NUM_CH)) begin
                // partial-word writes are dropped
                if (st_r.wstrb == 4'hf) begin
                    st_nxt.regs[st_r.aw_idx[2:0]] =
                        st_r.wdata & rmc_pkg::CH_WMASK;
                end
            end else if (st_r.aw_idx != rmc_pkg::STAT_IDX) begin
                st_nxt.bresp = rmc_pkg::RESP_DECERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = rmc_pkg::RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            if (s_axi_araddr[rmc_pkg::AXI_AW-1:2] <
                6'(rmc_pkg::NUM_CH)) begin
                st_nxt.rdata = st_r.regs[s_axi_araddr[4:2]];
            end else if (s_axi_araddr[rmc_pkg::AXI_AW-1:2] ==
                         rmc_pkg::STAT_IDX) begin
                st_nxt.rdata = {28'h0, st_r.state != rmc_pkg::ST_IDLE,
                    st_r.strap_done, st_r.sys_half, stat_mode};
            end else begin
                st_nxt.rresp = rmc_pkg::RESP_DECERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        // access engine
        case (st_r.state)
            rmc_pkg::ST_IDLE: begin
                if (mem_req && st_r.strap_done) begin
                    st_nxt.wr    = mem_write;
                    st_nxt.beat  = 4'h0;
                    st_nxt.pos   = 4'h0;
                    st_nxt.tick  = 1'b0;
                    st_nxt.ch    = hit_idx;
                    st_nxt.err   = !hit_any;
                    st_nxt.total = cycles(hreg, mem_burst, mem_size,
                                          mem_beats);
                    st_nxt.cnt   = wait_load(hreg, 1'b1);
                    if (hit_any) begin
                        st_nxt.state = rmc_pkg::ST_BEAT;
                        st_nxt.sel_n = ~(8'h01 << hit_idx);
                    end else begin
                        st_nxt.state = rmc_pkg::ST_FIN;
                    end
                end
            end
            rmc_pkg::ST_BEAT: begin
                // half speed steps only on every other edge
                if (creg[rmc_pkg::HS_BIT] && !st_r.tick) begin
                    st_nxt.tick = 1'b1;
                end else begin
                    st_nxt.tick = 1'b0;
                    if (st_r.cnt != 6'h00) begin
                        st_nxt.cnt = st_r.cnt - 6'h01;
                    end else if (!c_pin || pin_ok) begin
                        // internal ack only in normal and page
                        st_nxt.ack  = !c_pin;
                        st_nxt.beat = st_r.beat + 4'h1;
                        st_nxt.pos  = st_r.pos + 4'h1;
                        if (!c_page || st_r.pos + 4'h1 == plen) begin
                            st_nxt.pos = 4'h0; // new page burst
                        end
                        st_nxt.cnt = wait_load(creg, st_nxt.pos == 4'h0);
                        if (st_r.beat + 4'h1 == st_r.total) begin
                            st_nxt.state = rmc_pkg::ST_FIN;
                            st_nxt.sel_n = '1;
                        end
                    end
                end
            end
            rmc_pkg::ST_FIN: begin
                st_nxt.state = rmc_pkg::ST_IDLE;
            end
            default: begin
                st_nxt.state = rmc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.regs  <= {rmc_pkg::NUM_CH{rmc_pkg::CH_RESET}};
            st_r.state <= rmc_pkg::ST_IDLE;
            st_r.sel_n <= '1;
            st_r.pin_s1 <= 1'b1;
            st_r.pin_s2 <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign mem_done      = st_r.state == rmc_pkg::ST_FIN;
    assign mem_err       = mem_done && st_r.err;
    assign chan_sel_n    = st_r.sel_n;
    assign cycle_half_speed = (st_r.state == rmc_pkg::ST_BEAT) &&
                              creg[rmc_pkg::HS_BIT];
    assign cycle_write   = st_r.wr;
    assign ack_ready_out = !st_r.ack;
    // pin driven only in dynamic mode for internal ack
    assign ack_ready_oe  = !stat_mode && !c_pin &&
                           st_r.state == rmc_pkg::ST_BEAT;
    assign system_clock_half = st_r.sys_half;
    assign static_pin_mode   = stat_mode;

    sequence accept_s;
        st_r.state == rmc_pkg::ST_IDLE && mem_req && st_r.strap_done &&
        hit_any;
    endsequence
    sequence normal_s;
        !hreg[rmc_pkg::RDY_BIT] && hreg[rmc_pkg::PLEN_LSB +: 2] == 2'h0;
    endsequence

    static_pin_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        static_pin_mode |-> !ack_ready_oe)
        else $error("pin driven in static mode");
    dyn_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.state == rmc_pkg::ST_BEAT && !stat_mode && c_pin)
        |-> !ack_ready_oe)
        else $error("pin driven for input submode");
    normal_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (accept_s and normal_s) |=> st_r.cnt ==
        (($past(hwait) == rmc_pkg::WAIT_EXT) ? 6'h00 : $past(hwait)))
        else $error("normal wait count wrong");
    ready_even_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (accept_s and hreg[rmc_pkg::RDY_BIT]) |=> !st_r.cnt[0])
        else $error("odd ready wait count");
    page_first_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (accept_s and hreg[rmc_pkg::PLEN_LSB +: 2] != 2'h0 &&
        !hreg[rmc_pkg::RDY_BIT]) |=> st_r.cnt[5:4] == 2'h0)
        else $error("page first wait too wide");
    word16_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (accept_s and hreg[rmc_pkg::BUS16_BIT] && !mem_burst) |=>
        st_r.total == (($past(mem_size) == rmc_pkg::SZ_WORD) ? 4'h2 : 4'h1))
        else $error("16-bit split wrong");
    burst16_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (accept_s and hreg[rmc_pkg::BUS16_BIT] && mem_burst) |=>
        st_r.total == 4'h2)
        else $error("16-bit burst not two cycles");
    system_clock_out_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(st_r.strap_done) && $past(st_r.strap_s2[3:2]) == 2'h2 |->
        system_clock_half && st_r.regs[0][rmc_pkg::HS_BIT])
        else $error("boot half speed clock wrong");
    half_rate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.state == rmc_pkg::ST_BEAT && creg[rmc_pkg::HS_BIT] &&
        !st_r.tick && st_r.cnt != 6'h00) |=> st_r.cnt == $past(st_r.cnt))
        else $error("half speed counted early");
    enable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        accept_s |-> hreg[rmc_pkg::EN_BIT])
        else $error("disabled channel selected");
endmodule // rmc_external_memory_ctl
`default_nettype wire

// [dv/rmc_far_dev.sv]
/*
 * rmc_far_dev: external device on the shared ack/ready pin.
 * assumes the controller's core_clk and a select that is high in cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module rmc_far_dev (
    input  wire logic       core_clk,
    input  wire logic       sel,
    input  wire logic       ready_mode,
    input  wire logic [1:0] dly,
    output logic            pin_drv
);
    logic [2:0] cnt_r;
    always_ff @(posedge core_clk) begin
        if (!sel) cnt_r <= 3'h0;
        else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    end
    // active level after the delay, inactive level otherwise
    assign pin_drv = ready_mode ^ (!sel || cnt_r <= {1'b0, dly});
endmodule // rmc_far_dev
`default_nettype wire

// [dv/rmc_external_memory_ctl_tb.sv]
/*
 * rmc_external_memory_ctl_tb: strap, register and access scenarios.
 * assumes the controller and rmc_far_dev; one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rmc_external_memory_ctl_tb;
logic core_clk=0, reset_n=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
logic s_axi_arvalid=0, s_axi_rready=0, mem_req=0, mem_write=0, mem_burst=0;
logic global_half_speed_strap=0, boot_width16_strap_n=1, rmode=0, hsn=0;
logic [7:0] s_axi_awaddr=0, s_axi_araddr=0, chan_sel_n, lat=0, pl=0;
logic [2:0] s_axi_awprot=0, s_axi_arprot=0;
logic [31:0] s_axi_wdata=0, mem_addr=0, s_axi_rdata, e, m;
logic [3:0] s_axi_wstrb=4'hf, mem_beats=0;
logic [1:0] mem_size=0, boot_enable_straps=0, s_axi_bresp, s_axi_rresp, dly=0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic mem_done, mem_err, cycle_half_speed, cycle_write, ack_ready_in;
logic ack_ready_out, ack_ready_oe, system_clock_half, static_pin_mode, pin_drv;
logic [31:0] eq[$], mq[$];
int error_cnt=0, total_checks=0, seed=45865, i, w;
assign ack_ready_in = ack_ready_oe ? ack_ready_out : pin_drv;
rmc_external_memory_ctl dut (.*);
rmc_far_dev far (.core_clk(core_clk), .sel(!(&chan_sel_n)),
    .ready_mode(rmode), .dly(dly), .pin_drv(pin_drv));
initial forever #2.5 core_clk = !core_clk;
task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic chk(string nm, logic [31:0] ex, logic [31:0] sn);
    total_checks++;
    if (sn !== ex) begin
        error_cnt++;
        $display("Error %s expected %h seen %h", nm, ex, sn);
    end
endtask
task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
    s_axi_wdata <= d; s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    chk("bresp", rmc_pkg::RESP_OKAY, s_axi_bresp);
    if (n == 50) begin chk("write timeout", 0, 1); close_out(); end
endtask
task automatic rd(logic [7:0] a, logic [31:0] ex, logic [1:0] rs);
    int n;
    @(posedge core_clk);
    s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
    eq.push_back(ex); mq.push_back('1);
    for (n = 0; n < 50; n++) begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 0;
        if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    chk("rresp", rs, s_axi_rresp);
    if (n == 50) begin chk("read timeout", 0, 1); close_out(); end
endtask
// note {err, edges with request up, ack pulses}; mk picks the fields judged
task automatic mem(logic [31:0] a, logic [1:0] sz, logic b, logic [7:0] lt,
                   logic [7:0] np, logic er, logic [31:0] mk);
    int n;
    @(posedge core_clk);
    eq.push_back({15'h0, er, lt, np}); mq.push_back(mk);
    mem_req <= 1; mem_addr <= a; mem_size <= sz; mem_burst <= b;
    mem_beats <= 4'h4; mem_write <= $random(seed); dly <= $random(seed);
    for (n = 0; n < 400; n++) begin
        @(posedge core_clk);
        if (mem_done) break;
    end
    mem_req <= 0;
    $display("access test done");
    if (n == 400) begin chk("access timeout", 0, 1); close_out(); end
endtask
always @(posedge core_clk) begin
    if (mem_req) begin lat = lat + 1; if (ack_ready_out === 1'b0) pl++; end
    if (cycle_half_speed === 1'b1) hsn = 1;
    if (mem_done === 1'b1) chk("cycle write", mem_write, cycle_write);
    if (static_pin_mode === 1'b1) chk("pin enable", 0, ack_ready_oe);
    if ((s_axi_rvalid && s_axi_rready) || mem_done === 1'b1) begin
        if (eq.size() == 0) chk("queue", 0, 1);
        else begin
            e = eq.pop_front(); m = mq.pop_front();
            chk("result", e & m, (s_axi_rvalid ? s_axi_rdata
                : {15'h0, mem_err, lat, pl}) & m);
        end
        lat = 0; pl = 0;
    end
end
initial begin
    for (i = 0; i < 8; i++) begin
        reset_n <= 0; {boot_enable_straps, global_half_speed_strap} <= 3'(i);
        boot_width16_strap_n <= $random(seed);
        repeat (12) @(posedge core_clk);
        reset_n <= 1;
        repeat (6) @(posedge core_clk);
        chk("system_clock_out half", boot_enable_straps[1] ? !(boot_enable_straps[0]
            && global_half_speed_strap) : !global_half_speed_strap,
            system_clock_half);
        rd(8'h00, {!boot_width16_strap_n, 2'b0, !boot_enable_straps[0],
            boot_enable_straps[1], 3'b0}, 0);
        $display("strap test done");
    end
    w = $random(seed) & 7;
    wr(8'h04, 32'h1000_0008 | (w << 8));
    rd(8'h04, (32'h1000_0008 | (w << 8)) & rmc_pkg::CH_WMASK, 0);
    rd(8'h30, 0, rmc_pkg::RESP_DECERR);
    mem(32'h1000_0000 | ($random(seed) & 32'hffffc), 2, 0, w + 3, 1, 0,
        '1);
    chk("half cycle", 0, hsn);
    wr(8'h04, 32'h1000_0018);
    mem(32'h1000_0040, 2, 0, 4, 1, 0, '1);
    chk("half cycle", 1, hsn);
    hsn = 0;
    wr(8'h04, 32'h1000_0000);
    mem(32'h1000_0040, 2, 0, 0, 0, 1, 32'h1_0000);
    mem(32'hf000_0000, 2, 0, 0, 0, 1, 32'h1_0000);
    wr(8'h08, 32'h1506_0008);
    mem(32'h1420_0000, 2, 0, 3, 1, 0, '1);
    wr(8'h08, 32'h1506_0088);
    mem(32'h1420_0000, 2, 0, 0, 2, 0, 32'h1_00ff);
    mem(32'h1420_0002, 1, 0, 0, 1, 0, 32'h1_00ff);
    mem(32'h1420_0000, 0, 1, 0, 2, 0, 32'h1_00ff);
    wr(8'h0c, 32'h2000_4108);
    mem(32'h2000_0000, 2, 1, 0, 4, 0, 32'h1_00ff);
    wr(8'h10, 32'h3000_0248); rmode <= 1;
    mem(32'h3000_0000, 2, 0, 0, 0, 0, 32'h1_00ff);
    wr(8'h14, 32'h4000_3f08); rmode <= 0;
    mem(32'h4000_0000, 2, 0, 0, 0, 0, 32'h1_00ff);
    wr(8'h10, 32'h3000_0348); wr(8'h04, 32'h1000_0008);
    chk("static mode", 1, static_pin_mode);
    mem(32'h1000_0000, 2, 0, 0, 0, 0, 32'h1_0000);
    close_out();
end
endmodule // rmc_external_memory_ctl_tb
`default_nettype wire
